/* core/lpm_consts.vh */
// Constants for the low-power mode controller and its wakeup timer
//
// What this block does
// - Without fast wakeup, resume on the clock chosen before active-halt entry.
// - With fast wakeup, restart on internal fast oscillator; software may switch.
// - Fast wakeup enable resets off; software sets it before low-power entry.
// - Active-halt defaults: main regulator kept, flash left operating.
// - Regulator select bit uses low-power regulator in the active-halt halt phase.
// - Active-halt flash power-down bit powers flash down in the halt phase.
// - Wakeup timer runs from slow internal oscillator or prescaled external source.
// - Wakeup counters count only in active-halt halt phase, stop on wakeup.
// - Counters restart from zero on every halt phase entry.
// - Timer events raise a wakeup interrupt returning the core to run.
// - Interval spans 15.625 us to 30.720 s at a 128 kHz input.
// - Halt mode stops all clocks; memory and registers keep their values.
// - Halt mode turns main regulator off, only low-power regulator on.
// - Halt instruction enters halt unless timer or watchdog redirects it.
// - Halt wakes only on pin, CAN receive, SPI end, I2C match or reset.
// - Flash powers down on halt entry by default.
// - Halt flash keep-on bit keeps flash operating throughout halt.
// - Option bit selects external clock input or crystal for external source.
// - Enabled watchdog at halt sends device into active-halt halt phase.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH

// ------------------------------
// Timing
// ------------------------------
`define SYS_CLK_HZ     125000000
`define SLOW_OSC_HZ    128000
`define SLOW_DIV_CYC   (`SYS_CLK_HZ / `SLOW_OSC_HZ)
`define AWU_MIN_NS     15625
`define AWU_MAX_MS     30720
`define AWU_MIN_TICKS  ((`AWU_MIN_NS * (`SLOW_OSC_HZ / 1000)) / 1000000)
`define AWU_MAX_TICKS  (`AWU_MAX_MS * (`SLOW_OSC_HZ / 1000))

// ------------------------------
// Register offsets
// ------------------------------
`define OFS_CLK_CTRL   8'h00
`define OFS_FLASH_CTRL 8'h04
`define OFS_AWU_CTRL   8'h08
`define OFS_AWU_INTVL  8'h0C
`define OFS_STATUS     8'h10
`define OFS_WAKE_CAUSE 8'h14

// ------------------------------
// Field positions
// ------------------------------
`define CLK_FASTWU_BIT 0
`define CLK_LPREG_BIT  1
`define CLK_SRC_LSB    2
`define FL_AHPD_BIT    0
`define FL_KEEP_BIT    1
`define AWU_EN_BIT     0
`define ST_MODE_LSB    0
`define ST_CLK_LSB     2
`define ST_EXTERNAL_CLOCK_SELECT_BIT  4
`define ST_AWUEXT_BIT  5
`define WC_PIN         0
`define WC_CAN         1
`define WC_SPI         2
`define WC_I2C         3
`define WC_AWU         4

// ------------------------------
// Clock sources and reset values
// ------------------------------
`define CSRC_FAST      2'h0
`define CSRC_EXT       2'h1
`define CSRC_SLOW      2'h2
`define RST_FASTWU     1'h0
`define RST_LPREG      1'h0
`define RST_AHPD       1'h0
`define RST_KEEP       1'h0
`define RST_AWUEN      1'h0
`define RST_INTVL      22'h0_0080

`endif

/* core/awu_timer.v */
// Auto-wakeup timer: input tick selection and interval counter
`timescale 1ns/1ns
`include "lpm_consts.vh"

module awu_timer #(
  parameter CNT_W = 22,
  parameter PRE_W = 6,
  parameter DIV_W = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Control
  input  wire             run,
  input  wire             src_ext,
  input  wire             ext_tick,
  input  wire [PRE_W-1:0] wakeup_clock_prescaler,
  input  wire [CNT_W-1:0] interval,
  // Event
  output reg              fire
);

  localparam [31:0]      DIV_LAST_W = `SLOW_DIV_CYC - 1;
  localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_W[DIV_W-1:0];

  reg  [DIV_W-1:0] div_r;
  reg  [PRE_W-1:0] pre_r;
  reg  [CNT_W-1:0] cnt_r;
  wire [PRE_W-1:0] pre_top;
  wire             slow_tick;
  wire             ext_pulse;
  wire             tick;

  // Prescaler of zero behaves as divide by one
  assign pre_top   = (wakeup_clock_prescaler == {PRE_W{1'b0}}) ? {PRE_W{1'b0}} : wakeup_clock_prescaler - 1'b1;
  assign slow_tick = (div_r == DIV_LAST);
  assign ext_pulse = ext_tick & (pre_r == pre_top);
  assign tick      = src_ext ? ext_pulse : slow_tick;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= {DIV_W{1'b0}};
      pre_r <= {PRE_W{1'b0}};
      cnt_r <= {CNT_W{1'b0}};
      fire  <= 1'b0;
    end else if (!run) begin
      // Dividers clear too, so every interval starts from a whole tick
      div_r <= {DIV_W{1'b0}};
      pre_r <= {PRE_W{1'b0}};
      cnt_r <= {CNT_W{1'b0}};
      fire  <= 1'b0;
    end else begin
      div_r <= slow_tick ? {DIV_W{1'b0}} : div_r + 1'b1;
      if (ext_tick) begin
        pre_r <= (pre_r == pre_top) ? {PRE_W{1'b0}} : pre_r + 1'b1;
      end
      fire <= 1'b0;
      if (tick) begin
        if (cnt_r == interval - 1'b1) begin
          cnt_r <= {CNT_W{1'b0}};
          fire  <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

/* core/lowpower_mode_ctrl.v */
// Low-power mode controller: halt, active halt, wakeup and power steering
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "lpm_consts.vh"

module lowpower_mode_ctrl #(
  parameter CNT_W = 22,
  parameter PRE_W = 6
) (
  // Clock and reset
  input  wire             CLK_SYS,
  input  wire             RST_B,
  // APB slave
  input  wire             PSEL,
  input  wire             PENABLE,
  input  wire             PWRITE,
  input  wire [7:0]       PADDR,
  input  wire [31:0]      PWDATA,
  output reg  [31:0]      PRDATA,
  output reg              PREADY,
  output reg              PSLVERR,
  // Core side
  input  wire             HALT_EXEC,
  input  wire             WDOG_ENABLED,
  output reg              AWU_IRQ,
  output reg              WAKE_PULSE,
  output reg              CPU_CLK_EN,
  output reg              PERIPH_CLK_EN,
  // Wakeup sources
  input  wire             EXT_PIN_IRQ,
  input  wire             CAN_RX_IRQ,
  input  wire             SPI_EOT_IRQ,
  input  wire             I2C_ADDR_IRQ,
  // Option bytes and external source ticks
  input  wire             OPT_EXT_CLOCK,
  input  wire             OPT_AWU_EXT,
  input  wire [PRE_W-1:0] OPT_WAKEUP_CLOCK_PRESCALER,
  input  wire             EXT_TICK,
  // Power and clock steering
  output reg              MAIN_REG_ON,
  output reg              LP_REG_ON,
  output reg              FLASH_PWRDN,
  output reg  [1:0]       CLK_SRC,
  output reg              FAST_OSC_ON,
  output reg              EXT_OSC_ON,
  output reg              SLOW_OSC_ON,
  output reg              EXT_IS_CLOCK
);

  // ------------------------------
  // States
  // ------------------------------
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_HALT  = 2'h1;
  localparam [1:0] ST_ACTIVEHALT_FLASH_POWERDOWN = 2'h2;

  // Interval limits in ticks, cut to the counter width on purpose
  localparam [31:0]      INT_MIN_W = `AWU_MIN_TICKS;
  localparam [31:0]      INT_MAX_W = `AWU_MAX_TICKS;
  localparam [CNT_W-1:0] INT_MIN   = INT_MIN_W[CNT_W-1:0];
  localparam [CNT_W-1:0] INT_MAX   = INT_MAX_W[CNT_W-1:0];

  // ------------------------------
  // Declarations
  // ------------------------------
  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  reg              fast_wakeup_enable_r;
  reg              lowpower_regulator_select_r;
  reg              activehalt_flash_powerdown_r;
  reg              halt_flash_keep_r;
  reg              awu_en_r;
  reg  [CNT_W-1:0] interval_r;
  reg  [1:0]       clk_sel_r;
  reg  [4:0]       wake_cause_r;
  reg  [4:0]       cause_set;
  reg              lat_fastwu_r;
  reg              lat_lpreg_r;
  reg              lat_ahpd_r;
  reg              lat_keep_r;
  reg  [31:0]      rd_nxt;
  reg              hit;
  reg              wake;
  wire             setup;
  wire             wr_go;
  wire             pin_wake;
  wire             awu_fire;
  wire             awu_run;

  // ------------------------------
  // APB handshake
  // ------------------------------
  // PREADY is registered from the setup cycle: one access cycle, no wait state
  assign setup = PSEL & ~PENABLE;
  assign wr_go = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

  always @* begin
    rd_nxt = 32'h0000_0000;
    hit    = 1'b1;
    case (PADDR)
      `OFS_CLK_CTRL: begin
        rd_nxt[`CLK_FASTWU_BIT] = fast_wakeup_enable_r;
        rd_nxt[`CLK_LPREG_BIT]  = lowpower_regulator_select_r;
        rd_nxt[`CLK_SRC_LSB+1:`CLK_SRC_LSB] = clk_sel_r;
      end
      `OFS_FLASH_CTRL: begin
        rd_nxt[`FL_AHPD_BIT] = activehalt_flash_powerdown_r;
        rd_nxt[`FL_KEEP_BIT] = halt_flash_keep_r;
      end
      `OFS_AWU_CTRL: begin
        rd_nxt[`AWU_EN_BIT] = awu_en_r;
      end
      `OFS_AWU_INTVL: begin
        rd_nxt[CNT_W-1:0] = interval_r;
      end
      `OFS_STATUS: begin
        rd_nxt[`ST_MODE_LSB+1:`ST_MODE_LSB] = state_r;
        rd_nxt[`ST_CLK_LSB+1:`ST_CLK_LSB]   = clk_sel_r;
        rd_nxt[`ST_EXTERNAL_CLOCK_SELECT_BIT]              = EXT_IS_CLOCK;
        rd_nxt[`ST_AWUEXT_BIT]              = OPT_AWU_EXT;
      end
      `OFS_WAKE_CAUSE: begin
        rd_nxt[4:0] = wake_cause_r;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~hit;
      if (setup) begin
        PRDATA <= (PWRITE | ~hit) ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // ------------------------------
  // Software control bits
  // ------------------------------
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      fast_wakeup_enable_r         <= `RST_FASTWU;
      lowpower_regulator_select_r  <= `RST_LPREG;
      activehalt_flash_powerdown_r <= `RST_AHPD;
      halt_flash_keep_r            <= `RST_KEEP;
      awu_en_r                     <= `RST_AWUEN;
      interval_r                   <= `RST_INTVL;
    end else if (wr_go) begin
      case (PADDR)
        `OFS_CLK_CTRL: begin
          fast_wakeup_enable_r        <= PWDATA[`CLK_FASTWU_BIT];
          lowpower_regulator_select_r <= PWDATA[`CLK_LPREG_BIT];
        end
        `OFS_FLASH_CTRL: begin
          activehalt_flash_powerdown_r <= PWDATA[`FL_AHPD_BIT];
          halt_flash_keep_r            <= PWDATA[`FL_KEEP_BIT];
        end
        `OFS_AWU_CTRL: begin
          awu_en_r <= PWDATA[`AWU_EN_BIT];
        end
        `OFS_AWU_INTVL: begin
          // Out-of-range intervals are clamped to the supported span
          if (PWDATA < `AWU_MIN_TICKS) begin
            interval_r <= INT_MIN;
          end else if (PWDATA > `AWU_MAX_TICKS) begin
            interval_r <= INT_MAX;
          end else begin
            interval_r <= PWDATA[CNT_W-1:0];
          end
        end
        default: begin
          interval_r <= interval_r;
        end
      endcase
    end
  end

  // ------------------------------
  // Wakeup timer
  // ------------------------------
  // Outside a timer-enabled active halt the timer is held cleared
  assign awu_run  = (state_r == ST_ACTIVEHALT_FLASH_POWERDOWN) & awu_en_r;
  assign pin_wake = EXT_PIN_IRQ | CAN_RX_IRQ | SPI_EOT_IRQ | I2C_ADDR_IRQ;

  awu_timer #(
    .CNT_W (CNT_W),
    .PRE_W (PRE_W)
  ) u_awu (
    .clk      (CLK_SYS),
    .rst_b    (RST_B),
    .run      (awu_run),
    .src_ext  (OPT_AWU_EXT),
    .ext_tick (EXT_TICK),
    .wakeup_clock_prescaler    (OPT_WAKEUP_CLOCK_PRESCALER),
    .interval (interval_r),
    .fire     (awu_fire)
  );

  // ------------------------------
  // Mode sequencing
  // ------------------------------
  always @* begin
    state_nxt = state_r;
    wake      = 1'b0;
    cause_set = 5'h00;
    case (state_r)
      ST_RUN: begin
        if (HALT_EXEC) begin
          // Watchdog alone also forces active halt; it then has no timer wake
          if (awu_en_r | WDOG_ENABLED) begin
            state_nxt = ST_ACTIVEHALT_FLASH_POWERDOWN;
          end else begin
            state_nxt = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        wake = pin_wake;
      end
      ST_ACTIVEHALT_FLASH_POWERDOWN: begin
        // Without the timer this is a watchdog-only stop: a reset alone ends it
        if (awu_en_r) begin
          wake = pin_wake | awu_fire;
        end else begin
          wake = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (wake) begin
      state_nxt             = ST_RUN;
      cause_set[`WC_PIN]    = EXT_PIN_IRQ;
      cause_set[`WC_CAN]    = CAN_RX_IRQ;
      cause_set[`WC_SPI]    = SPI_EOT_IRQ;
      cause_set[`WC_I2C]    = I2C_ADDR_IRQ;
      cause_set[`WC_AWU]    = awu_fire;
    end
  end

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_r      <= ST_RUN;
      lat_fastwu_r <= 1'b0;
      lat_lpreg_r  <= 1'b0;
      lat_ahpd_r   <= 1'b0;
      lat_keep_r   <= 1'b0;
      clk_sel_r    <= `CSRC_FAST;
      wake_cause_r <= 5'h00;
      WAKE_PULSE   <= 1'b0;
      AWU_IRQ      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      WAKE_PULSE <= wake;
      AWU_IRQ    <= wake & awu_fire;
      // Snapshot at entry so a late write cannot disturb a stopped core
      if (state_r == ST_RUN && HALT_EXEC) begin
        lat_fastwu_r <= fast_wakeup_enable_r;
        lat_lpreg_r  <= lowpower_regulator_select_r;
        lat_ahpd_r   <= activehalt_flash_powerdown_r;
        lat_keep_r   <= halt_flash_keep_r;
      end
      // A latched fast wakeup forces the fast oscillator; otherwise the choice stays
      if (wake && lat_fastwu_r) begin
        clk_sel_r <= `CSRC_FAST;
      end else if (wake) begin
        clk_sel_r <= clk_sel_r;
      end else if (wr_go && PADDR == `OFS_CLK_CTRL &&
                   PWDATA[`CLK_SRC_LSB+1:`CLK_SRC_LSB] != 2'h3) begin
        clk_sel_r <= PWDATA[`CLK_SRC_LSB+1:`CLK_SRC_LSB];
      end
      // Write one to clear; a cause arriving together is kept
      if (wr_go && PADDR == `OFS_WAKE_CAUSE) begin
        wake_cause_r <= (wake_cause_r & ~PWDATA[4:0]) | cause_set;
      end else begin
        wake_cause_r <= wake_cause_r | cause_set;
      end
    end
  end

  // ------------------------------
  // Power, flash and clock steering
  // ------------------------------
  // Outputs follow the mode one cycle later, all from flip-flops
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      CPU_CLK_EN    <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      MAIN_REG_ON   <= 1'b1;
      LP_REG_ON     <= 1'b0;
      FLASH_PWRDN   <= 1'b0;
      CLK_SRC       <= `CSRC_FAST;
      FAST_OSC_ON   <= 1'b1;
      EXT_OSC_ON    <= 1'b0;
      SLOW_OSC_ON   <= 1'b0;
      EXT_IS_CLOCK  <= 1'b0;
    end else begin
      EXT_IS_CLOCK <= OPT_EXT_CLOCK;
      CLK_SRC      <= clk_sel_r;
      case (state_r)
        ST_HALT: begin
          CPU_CLK_EN    <= 1'b0;
          PERIPH_CLK_EN <= 1'b0;
          MAIN_REG_ON   <= 1'b0;
          LP_REG_ON     <= 1'b1;
          FLASH_PWRDN   <= ~lat_keep_r;
          FAST_OSC_ON   <= 1'b0;
          EXT_OSC_ON    <= 1'b0;
          SLOW_OSC_ON   <= 1'b0;
        end
        ST_ACTIVEHALT_FLASH_POWERDOWN: begin
          CPU_CLK_EN    <= 1'b0;
          PERIPH_CLK_EN <= 1'b0;
          MAIN_REG_ON   <= ~lat_lpreg_r;
          LP_REG_ON     <= lat_lpreg_r;
          FLASH_PWRDN   <= lat_ahpd_r;
          FAST_OSC_ON   <= 1'b0;
          EXT_OSC_ON    <= awu_en_r & OPT_AWU_EXT;
          SLOW_OSC_ON   <= (awu_en_r & ~OPT_AWU_EXT) | WDOG_ENABLED;
        end
        default: begin
          CPU_CLK_EN    <= 1'b1;
          PERIPH_CLK_EN <= 1'b1;
          MAIN_REG_ON   <= 1'b1;
          LP_REG_ON     <= 1'b0;
          FLASH_PWRDN   <= 1'b0;
          FAST_OSC_ON   <= (clk_sel_r == `CSRC_FAST);
          EXT_OSC_ON    <= (clk_sel_r == `CSRC_EXT);
          SLOW_OSC_ON   <= (clk_sel_r == `CSRC_SLOW) | WDOG_ENABLED;
        end
      endcase
    end
  end

endmodule

/* verif/lpm_core_model.sv */
// Model of the core and the wakeup sources facing the low-power controller
`timescale 1ns/1ns
module lpm_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bench commands
  input  wire logic       go_halt,
  input  wire logic [3:0] go_wake,
  // Controller side
  input  wire logic       woke,
  output logic            halt_exec,
  output logic [3:0]      wake_req
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_exec <= 1'b0;
      wake_req  <= 4'h0;
    end else begin
      halt_exec <= go_halt;
      // Requests stay up until the wakeup is taken, as an unserviced source would
      wake_req  <= (wake_req | go_wake) & ~{4{woke}};
    end
  end
endmodule

/* verif/lowpower_mode_ctrl_properties.sv */
// Port-level checker for the low-power mode controller
`timescale 1ns/1ns
module lowpower_mode_ctrl_properties (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Core side
  input wire logic HALT_EXEC,
  input wire logic AWU_IRQ,
  input wire logic WAKE_PULSE,
  input wire logic CPU_CLK_EN,
  input wire logic PERIPH_CLK_EN,
  input wire logic WDOG_ENABLED,
  // Wakeup sources
  input wire logic EXT_PIN_IRQ,
  input wire logic CAN_RX_IRQ,
  input wire logic SPI_EOT_IRQ,
  input wire logic I2C_ADDR_IRQ,
  // Power and options
  input wire logic MAIN_REG_ON,
  input wire logic LP_REG_ON,
  input wire logic FLASH_PWRDN,
  input wire logic SLOW_OSC_ON,
  input wire logic OPT_EXT_CLOCK,
  input wire logic EXT_IS_CLOCK
);
  wire any_src = EXT_PIN_IRQ | CAN_RX_IRQ | SPI_EOT_IRQ | I2C_ADDR_IRQ;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  property p_halt_entry;
    HALT_EXEC && CPU_CLK_EN && !any_src |-> ##2 !CPU_CLK_EN;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
  property p_wake_src;
    // A watchdog stop may have no timer behind it, and then pins do not wake it
    !CPU_CLK_EN && !WAKE_PULSE && any_src && !(WDOG_ENABLED && SLOW_OSC_ON)
      |-> ##[1:2] WAKE_PULSE;
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("source did not wake");
  property p_only_src;
    $rose(WAKE_PULSE) |-> $past(any_src) || AWU_IRQ;
  endproperty
  a_only_src: assert property (p_only_src) else $error("wake without source");
  property p_awu_halted;
    AWU_IRQ |-> WAKE_PULSE && !CPU_CLK_EN;
  endproperty
  a_awu_halted: assert property (p_awu_halted) else $error("timer event in run");
  property p_resume;
    WAKE_PULSE |=> !WAKE_PULSE && CPU_CLK_EN && PERIPH_CLK_EN;
  endproperty
  a_resume: assert property (p_resume) else $error("no return to run");
  property p_regs;
    MAIN_REG_ON != LP_REG_ON;
  endproperty
  a_regs: assert property (p_regs) else $error("regulator pair wrong");
  property p_run_power;
    CPU_CLK_EN |-> MAIN_REG_ON && !FLASH_PWRDN;
  endproperty
  a_run_power: assert property (p_run_power) else $error("run power wrong");
  property p_clk_pair;
    CPU_CLK_EN == PERIPH_CLK_EN;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock enables split");
  property p_ext_opt;
    EXT_IS_CLOCK == $past(OPT_EXT_CLOCK);
  endproperty
  a_ext_opt: assert property (p_ext_opt) else $error("option copy wrong");
endmodule

bind lowpower_mode_ctrl lowpower_mode_ctrl_properties i_lowpower_mode_ctrl_properties (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HALT_EXEC(HALT_EXEC), .AWU_IRQ(AWU_IRQ),
  .WAKE_PULSE(WAKE_PULSE), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .EXT_PIN_IRQ(EXT_PIN_IRQ), .CAN_RX_IRQ(CAN_RX_IRQ), .SPI_EOT_IRQ(SPI_EOT_IRQ),
  .I2C_ADDR_IRQ(I2C_ADDR_IRQ), .MAIN_REG_ON(MAIN_REG_ON), .LP_REG_ON(LP_REG_ON),
  .FLASH_PWRDN(FLASH_PWRDN), .OPT_EXT_CLOCK(OPT_EXT_CLOCK), .EXT_IS_CLOCK(EXT_IS_CLOCK),
  .WDOG_ENABLED(WDOG_ENABLED), .SLOW_OSC_ON(SLOW_OSC_ON));

/* verif/lowpower_mode_ctrl_tb.sv */
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ns
`include "lpm_consts.vh"
module lowpower_mode_ctrl_tb;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        wdog, opt_ext, opt_awu, tick, go_halt, halt_exec, awu_irq, wake;
  logic        cpu_en, per_en, main_on, lp_on, fl_pd, fast_on, ext_on, slow_on, ext_is;
  logic [5:0]  wakeup_clock_prescaler;
  logic [3:0]  go_wake, req;
  logic [1:0]  csrc;
  int          n_fail, samples_checked, n1, n2;

  always #4 clk = ~clk;

  lowpower_mode_ctrl i_lowpower_mode_ctrl (
    .CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HALT_EXEC(halt_exec), .WDOG_ENABLED(wdog), .AWU_IRQ(awu_irq), .WAKE_PULSE(wake),
    .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .EXT_PIN_IRQ(req[0]),
    .CAN_RX_IRQ(req[1]), .SPI_EOT_IRQ(req[2]), .I2C_ADDR_IRQ(req[3]),
    .OPT_EXT_CLOCK(opt_ext), .OPT_AWU_EXT(opt_awu), .OPT_WAKEUP_CLOCK_PRESCALER(wakeup_clock_prescaler), .EXT_TICK(tick),
    .MAIN_REG_ON(main_on), .LP_REG_ON(lp_on), .FLASH_PWRDN(fl_pd), .CLK_SRC(csrc),
    .FAST_OSC_ON(fast_on), .EXT_OSC_ON(ext_on), .SLOW_OSC_ON(slow_on),
    .EXT_IS_CLOCK(ext_is));

  lpm_core_model i_lpm_core_model (
    .clk(clk), .rst_b(rst_b), .go_halt(go_halt), .go_wake(go_wake), .woke(wake),
    .halt_exec(halt_exec), .wake_req(req));

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      n_fail++;
    end
  endtask

  // Request held until pready is sampled high; one idle cycle keeps drives apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask

  task halt_it;
    go_halt <= 1'b1;
    @(posedge clk);
    go_halt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Waits for the wakeup, checks its cause, then clears the sticky causes
  task wake_on(input logic [3:0] src, input logic [4:0] cause);
    int n;
    n = 0;
    go_wake <= src;
    @(posedge clk);
    go_wake <= 4'h0;
    while (wake !== 1'b1 && n < 3000) begin
      n++;
      @(posedge clk);
    end
    n1 = n;
    chk("wake_pulse", 32'h1, {31'h0, wake});
    chk("awu_irq", {31'h0, cause[4]}, {31'h0, awu_irq});
    repeat (2) @(posedge clk);
    chk("cpu_clk_en", 32'h1, {31'h0, cpu_en});
    rd(`OFS_WAKE_CAUSE, {27'h0, cause}, "wake_cause");
    wr(`OFS_WAKE_CAUSE, 32'h0000_001F);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wdog, opt_ext, go_halt, go_wake} = '0;
    {opt_awu, tick, wakeup_clock_prescaler} = {1'b1, 1'b1, 6'h03};
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // ----
    // Reset values, map and interval limits
    // ----
    rd(`OFS_CLK_CTRL, 32'h0000_0000, "clk_ctrl");
    rd(`OFS_AWU_INTVL, `RST_INTVL, "intvl");
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("pslverr", 32'h1, {31'h0, e});
    wr(`OFS_AWU_INTVL, 32'h0000_0001);
    rd(`OFS_AWU_INTVL, 32'h0000_0002, "intvl_min");
    wr(`OFS_AWU_INTVL, 32'h003F_FFFF);
    rd(`OFS_AWU_INTVL, 32'h003C_0000, "intvl_max");
    // ----
    // Halt and its wake sources
    // ----
    for (int i = 0; i < 4; i++) begin
      halt_it();
      chk("cpu_clk_en", 32'h0, {31'h0, cpu_en});
      chk("main_reg", 32'h0, {31'h0, main_on});
      chk("lp_reg", 32'h1, {31'h0, lp_on});
      chk("flash_pd", 32'h1, {31'h0, fl_pd});
      chk("fast_osc", 32'h0, {31'h0, fast_on});
      chk("slow_osc", 32'h0, {31'h0, slow_on});
      wake_on(4'h1 << i, 5'h01 << i);
    end
    wr(`OFS_FLASH_CTRL, 32'h0000_0002);
    halt_it();
    chk("flash_pd", 32'h0, {31'h0, fl_pd});
    wake_on(4'h1, 5'h01);
    wr(`OFS_CLK_CTRL, 32'h0000_0004);
    halt_it();
    wake_on(4'h2, 5'h02);
    chk("clk_src", {30'h0, `CSRC_EXT}, {30'h0, csrc});
    chk("ext_osc", 32'h1, {31'h0, ext_on});
    wr(`OFS_CLK_CTRL, 32'h0000_0005);
    halt_it();
    wake_on(4'h2, 5'h02);
    chk("clk_src", {30'h0, `CSRC_FAST}, {30'h0, csrc});
    // ----
    // Watchdog-only active halt ends by reset alone; then timer active halt
    // ----
    wr(`OFS_CLK_CTRL, 32'h0000_0001);
    wr(`OFS_FLASH_CTRL, 32'h0000_0000);
    wdog <= 1'b1;
    halt_it();
    rd(`OFS_STATUS, 32'h0000_0022, "status");
    go_wake <= 4'h4;
    @(posedge clk);
    go_wake <= 4'h0;
    repeat (10) @(posedge clk);
    chk("cpu_clk_en", 32'h0, {31'h0, cpu_en});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wdog <= 1'b0;
    @(posedge clk);
    chk("cpu_clk_en", 32'h1, {31'h0, cpu_en});
    rd(`OFS_CLK_CTRL, 32'h0000_0000, "clk_ctrl");
    wr(`OFS_AWU_CTRL, 32'h0000_0001);
    halt_it();
    chk("main_reg", 32'h1, {31'h0, main_on});
    chk("flash_pd", 32'h0, {31'h0, fl_pd});
    chk("ext_osc", 32'h1, {31'h0, ext_on});
    wake_on(4'h4, 5'h04);
    wr(`OFS_CLK_CTRL, 32'h0000_0002);
    wr(`OFS_FLASH_CTRL, 32'h0000_0001);
    halt_it();
    chk("lp_reg", 32'h1, {31'h0, lp_on});
    chk("flash_pd", 32'h1, {31'h0, fl_pd});
    wake_on(4'h8, 5'h08);
    // ----
    // Timer wakeups: external ticks divided by 3, then the slow oscillator
    // ----
    wr(`OFS_FLASH_CTRL, 32'h0000_0000);
    wr(`OFS_CLK_CTRL, 32'h0000_0000);
    wr(`OFS_AWU_INTVL, 32'h0000_000A);
    wr(`OFS_AWU_CTRL, 32'h0000_0001);
    halt_it();
    wake_on(4'h0, 5'h10);
    n2 = n1;
    halt_it();
    wake_on(4'h1, 5'h01);
    halt_it();
    wake_on(4'h0, 5'h10);
    chk("restart", n2, n1);
    chk("ext_ticks", 32'h1, {31'h0, n1 > 20 && n1 < 34});
    opt_awu <= 1'b0;
    wr(`OFS_AWU_INTVL, 32'h0000_0002);
    halt_it();
    chk("slow_osc", 32'h1, {31'h0, slow_on});
    wake_on(4'h0, 5'h10);
    chk("slow_ticks", 32'h1, {31'h0, n1 > 1940 && n1 < 1962});
    opt_ext <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ext_is_clock", 32'h1, {31'h0, ext_is});
    test_done();
  end
endmodule
